// ### src/timer2_params.svh
/*
 * constants for the asynchronous 8-bit timer: register offsets, field
 * positions, counter limits, prescaler masks and the transfer edge count.
 * assumes inclusion by bare name from the timer design files.
 */
`ifndef TIMER2_PARAMS_SVH
`define TIMER2_PARAMS_SVH

// ==========================================================
// register offsets in the cpu i/o space
`define T2_OFS_STATUS   6'h22
`define T2_OFS_COMPARE  6'h23
`define T2_OFS_COUNT    6'h24
`define T2_OFS_CONTROL  6'h25

// ==========================================================
// field positions
`define T2_MODE_LO_BIT  6
`define T2_MODE_HI_BIT  3
`define T2_ACT_HI_BIT   5
`define T2_ACT_LO_BIT   4
`define T2_CS_HI_BIT    2
`define T2_ASYNC_BIT    3

// ==========================================================
// reset values and counter limits
`define T2_RST8         8'h00
`define T2_RST7         7'h00
`define T2_MAX          8'hff
`define T2_BOTTOM       8'h00

// ==========================================================
// prescaler taps: tick when all masked bits of the divider are set
`define T2_MASK_8       10'h007
`define T2_MASK_32      10'h01f
`define T2_MASK_64      10'h03f
`define T2_MASK_128     10'h07f
`define T2_MASK_256     10'h0ff
`define T2_MASK_1024    10'h3ff

// ==========================================================
// crystal edges before a staged value lands
`define T2_XFER_EDGES   2'h2

`endif

// ### src/timer2_pkg.sv
/*
 * types shared by the timer design files.
 * assumes nothing of its surroundings.
 */
package timer2_pkg;

    // waveform mode, {hi, lo}
    typedef enum logic [1:0] {
        MODE_NORMAL = 2'h0,
        MODE_PHASE  = 2'h1,
        MODE_CTC    = 2'h2,
        MODE_FAST   = 2'h3
    } wave_mode_t;

    // clock select codes
    typedef enum logic [2:0] {
        CS_STOP = 3'h0, CS_DIV1 = 3'h1, CS_DIV8 = 3'h2, CS_DIV32 = 3'h3,
        CS_DIV64 = 3'h4, CS_DIV128 = 3'h5, CS_DIV256 = 3'h6,
        CS_DIV1024 = 3'h7
    } clk_sel_t;

endpackage

// ### src/timer2_prescaler.sv
/*
 * prescaler of the timer: divides a source tick by the selected ratio.
 * assumes src_tick is a one-cycle pulse on the same clock.
 */
`timescale 1ns/1ps
`include "timer2_params.svh"

module timer2_prescaler (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       rstn,
    // source and selection
    input  wire logic       src_tick,
    input  wire logic [2:0] sel,
    // divided tick
    output logic            tick
);

    logic [9:0] div_q;

    // mask of divider bits that must all be set for a tick
    function automatic logic [9:0] tap_mask(input logic [2:0] s);
        case (timer2_pkg::clk_sel_t'(s))
            timer2_pkg::CS_DIV8:    tap_mask = `T2_MASK_8;
            timer2_pkg::CS_DIV32:   tap_mask = `T2_MASK_32;
            timer2_pkg::CS_DIV64:   tap_mask = `T2_MASK_64;
            timer2_pkg::CS_DIV128:  tap_mask = `T2_MASK_128;
            timer2_pkg::CS_DIV256:  tap_mask = `T2_MASK_256;
            default:                tap_mask = `T2_MASK_1024;
        endcase
    endfunction

    // free divider advanced by every source tick
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            div_q <= 10'h000;
        end else if (src_tick) begin
            div_q <= div_q + 10'h001;
        end
    end

    // stop, undivided or tapped
    always_comb begin
        if (sel == timer2_pkg::CS_STOP) begin
            tick = 1'b0;
        end else if (sel == timer2_pkg::CS_DIV1) begin
            tick = src_tick;
        end else begin
            tick = src_tick && ((div_q & tap_mask(sel)) == tap_mask(sel));
        end
    end

endmodule

// ### src/async_timer2_control.sv
/*
 * 8-bit timer/counter with compare output and asynchronous crystal mode.
 * assumes a cpu i/o port on clock; crystal_clock_in is an unsynchronised
 * pin far slower than clock; the port direction bit lives outside.
 */
`timescale 1ns/1ps
`include "timer2_params.svh"

module async_timer2_control (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       rstn,
    // cpu i/o register port
    input  wire logic [5:0] io_addr,
    input  wire logic       io_wr,
    input  wire logic       io_rd,
    input  wire logic [7:0] io_wdata,
    output logic      [7:0] io_rdata,
    // crystal oscillator pin
    input  wire logic       crystal_clock_in,
    // compare output and events
    output logic            compare_output_pin,
    output logic            pin_override,
    output logic            overflow_flag,
    output logic            compare_match
);

    // ==========================================================
    // declarations
    logic [2:0] xsync_q;
    logic       xlvl_q;
    logic       xrise;
    logic       async_clock_sel_q;
    logic [6:0] ctl_stage_q;
    logic [6:0] ctl_q;
    logic [7:0] ocr_stage_q;
    logic [7:0] ocr_buf_q;
    logic [7:0] ocr_act_q;
    logic [7:0] cnt_stage_q;
    logic [7:0] cnt_q;
    logic       down_q;
    logic       block_q;
    logic [2:0] pend_q;
    logic [1:0] edges_q [3];
    logic [2:0] wr_vec;
    logic [2:0] apply_vec;
    logic       tick;
    logic       match;
    logic       ovf;
    logic       top_hit;
    logic [7:0] top;
    logic [7:0] rdata_q;
    logic       pin_q;
    logic       override_q;
    logic       ovf_q;
    logic       match_q;
    timer2_pkg::wave_mode_t mode;
    logic [1:0] act;

    assign io_rdata           = rdata_q;
    assign compare_output_pin = pin_q;
    assign pin_override       = override_q;
    assign overflow_flag      = ovf_q;
    assign compare_match      = match_q;

    // ==========================================================
    // control fields
    assign mode = timer2_pkg::wave_mode_t'({ctl_q[`T2_MODE_HI_BIT],
                                            ctl_q[`T2_MODE_LO_BIT]});
    assign act  = ctl_q[`T2_ACT_HI_BIT:`T2_ACT_LO_BIT];
    assign top  = (mode == timer2_pkg::MODE_CTC) ? ocr_act_q : `T2_MAX;

    // ==========================================================
    // crystal pin sampling
    // three stages; a level counts once stages two and three agree
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            xsync_q <= 3'h0;
        end else begin
            xsync_q <= {xsync_q[1:0], crystal_clock_in};
        end
    end

    // filtered crystal level
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            xlvl_q <= 1'b0;
        end else if (xsync_q[1] == xsync_q[2]) begin
            xlvl_q <= xsync_q[2];
        end
    end

    assign xrise = (xsync_q[1] == xsync_q[2]) && xsync_q[2] && !xlvl_q;

    // ==========================================================
    // register writes and staging
    assign wr_vec = {io_wr && io_addr == `T2_OFS_COUNT,
                     io_wr && io_addr == `T2_OFS_COMPARE,
                     io_wr && io_addr == `T2_OFS_CONTROL};

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            async_clock_sel_q <= 1'b0;
        end else if (io_wr && io_addr == `T2_OFS_STATUS) begin
            async_clock_sel_q <= io_wdata[`T2_ASYNC_BIT];
        end
    end

    // staging registers for control, compare and count; force bit dropped
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ctl_stage_q <= `T2_RST7;
            ocr_stage_q <= `T2_RST8;
            cnt_stage_q <= `T2_RST8;
        end else begin
            if (wr_vec[0]) ctl_stage_q <= io_wdata[6:0];
            if (wr_vec[1]) ocr_stage_q <= io_wdata;
            if (wr_vec[2]) cnt_stage_q <= io_wdata;
        end
    end

    // pending bits and crystal edge counts
    // pending holds until the timer side has taken the value
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pend_q <= 3'h0;
            for (int i = 0; i < 3; i++) edges_q[i] <= 2'h0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (wr_vec[i] && async_clock_sel_q) begin
                    pend_q[i]  <= 1'b1;
                    edges_q[i] <= 2'h0;
                end else if (pend_q[i] && xrise) begin
                    if (edges_q[i] == `T2_XFER_EDGES - 2'h1) begin
                        pend_q[i] <= 1'b0;
                    end
                    edges_q[i] <= edges_q[i] + 2'h1;
                end
            end
        end
    end

    // apply after two crystal edges, or at once when synchronous
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            if (async_clock_sel_q) begin
                apply_vec[i] = pend_q[i] && xrise && !wr_vec[i]
                    && edges_q[i] == `T2_XFER_EDGES - 2'h1;
            end else begin
                apply_vec[i] = wr_vec[i];
            end
        end
    end

    // live control and buffered compare
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ctl_q     <= `T2_RST7;
            ocr_buf_q <= `T2_RST8;
        end else begin
            if (apply_vec[0]) begin
                ctl_q <= async_clock_sel_q ? ctl_stage_q : io_wdata[6:0];
            end
            if (apply_vec[1]) begin
                ocr_buf_q <= async_clock_sel_q ? ocr_stage_q : io_wdata;
            end
        end
    end

    // ==========================================================
    // timer clock
    // prescaler from the selected source
    timer2_prescaler u_prescaler (
        .clock    (clock),
        .rstn     (rstn),
        .src_tick (async_clock_sel_q ? xrise : 1'b1),
        .sel      (ctl_q[`T2_CS_HI_BIT:0]),
        .tick     (tick)
    );

    // compare double buffer, loaded at once or at the ceiling
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ocr_act_q <= `T2_RST8;
        end else if (mode == timer2_pkg::MODE_NORMAL ||
                     mode == timer2_pkg::MODE_CTC) begin
            ocr_act_q <= ocr_buf_q;
        end else if (tick && cnt_q == `T2_MAX) begin
            ocr_act_q <= ocr_buf_q;
        end
    end

    // counter with load, wrap and up/down
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cnt_q  <= `T2_RST8;
            down_q <= 1'b0;
        end else if (apply_vec[2]) begin
            cnt_q <= async_clock_sel_q ? cnt_stage_q : io_wdata;
        end else if (tick) begin
            case (mode)
                timer2_pkg::MODE_PHASE: begin
                    if (!down_q && cnt_q == `T2_MAX) begin
                        down_q <= 1'b1;
                        cnt_q  <= cnt_q - 8'h01;
                    end else if (down_q && cnt_q == `T2_BOTTOM) begin
                        down_q <= 1'b0;
                        cnt_q  <= cnt_q + 8'h01;
                    end else begin
                        cnt_q <= down_q ? cnt_q - 8'h01 : cnt_q + 8'h01;
                    end
                end
                default: begin
                    down_q <= 1'b0;
                    cnt_q  <= (cnt_q == top) ? `T2_BOTTOM : cnt_q + 8'h01;
                end
            endcase
        end
    end

    // a counter write masks the match of the next tick
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            block_q <= 1'b0;
        end else if (apply_vec[2]) begin
            block_q <= 1'b1;
        end else if (tick) begin
            block_q <= 1'b0;
        end
    end

    assign match   = tick && !block_q && cnt_q == ocr_act_q;
    // compare at the ceiling with upper action bit set
    assign top_hit = ocr_act_q == `T2_MAX && act[1];
    // overflow at max, or at bottom in phase correct
    assign ovf = tick && ((mode == timer2_pkg::MODE_PHASE)
                          ? (down_q && cnt_q == `T2_BOTTOM)
                          : (cnt_q == `T2_MAX));

    // event pulses
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ovf_q   <= 1'b0;
            match_q <= 1'b0;
        end else begin
            ovf_q   <= ovf;
            match_q <= match;
        end
    end

    // ==========================================================
    // compare output pin
    // pin override whenever an action is selected
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            override_q <= 1'b0;
        end else begin
            override_q <= |act;
        end
    end

    // waveform per mode and action
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pin_q <= 1'b0;
        end else begin
            case (mode)
                // fast pwm, bottom action then match action
                timer2_pkg::MODE_FAST: begin
                    if (tick && cnt_q == `T2_MAX && act[1]) begin
                        pin_q <= ~act[0];
                    end else if (match && act[1] && !top_hit) begin
                        pin_q <= act[0];
                    end
                end
                // phase pwm, direction decides the level
                timer2_pkg::MODE_PHASE: begin
                    if (top_hit && tick && cnt_q == `T2_MAX) begin
                        pin_q <= act[0];
                    end else if (match && act[1] && !top_hit) begin
                        pin_q <= down_q ? ~act[0] : act[0];
                    end
                end
                // toggle, clear or set on match
                default: begin
                    if (match && act == 2'h1) begin
                        pin_q <= ~pin_q;
                    end else if (match && act[1]) begin
                        pin_q <= act[0];
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // register reads
    // staged compare and control, live counter
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rdata_q <= `T2_RST8;
        end else if (io_rd) begin
            case (io_addr)
                `T2_OFS_STATUS:  rdata_q <= {4'h0, async_clock_sel_q,
                                             pend_q};
                `T2_OFS_COMPARE: rdata_q <= ocr_stage_q;
                `T2_OFS_COUNT:   rdata_q <= cnt_q;
                `T2_OFS_CONTROL: rdata_q <= {1'b0, ctl_stage_q};
                default:         rdata_q <= `T2_RST8;
            endcase
        end
    end

    // ==========================================================
    // assertions
    property p_stop;
        @(posedge clock) disable iff (!rstn)
        (ctl_q[2:0] == 3'h0 && !apply_vec[2]) |=> $stable(cnt_q);
    endproperty
    a_stop: assert property (p_stop) else $error("count moved while stopped");

    property p_ctc_wrap;
        @(posedge clock) disable iff (!rstn)
        (mode == timer2_pkg::MODE_CTC && tick && cnt_q == ocr_act_q
         && !apply_vec[2]) |=> cnt_q == `T2_BOTTOM;
    endproperty
    a_ctc_wrap: assert property (p_ctc_wrap) else $error("ctc no wrap");

    property p_ovf_cause;
        @(posedge clock) disable iff (!rstn)
        ovf_q |-> ($past(cnt_q) == `T2_MAX || $past(cnt_q) == `T2_BOTTOM);
    endproperty
    a_ovf_cause: assert property (p_ovf_cause) else $error("bad overflow");

    property p_pend_set;
        @(posedge clock) disable iff (!rstn)
        (wr_vec[2] && async_clock_sel_q) |=> pend_q[2] [*2];
    endproperty
    a_pend_set: assert property (p_pend_set) else $error("pending lost");

    property p_pend_clear;
        @(posedge clock) disable iff (!rstn)
        $fell(pend_q[1]) |-> $past(xrise) && $past(async_clock_sel_q);
    endproperty
    a_pend_clear: assert property (p_pend_clear) else $error("early clear");

    property p_block;
        @(posedge clock) disable iff (!rstn)
        apply_vec[2] ##1 (tick && !apply_vec[2]) |=> !match_q;
    endproperty
    a_block: assert property (p_block) else $error("match not masked");

    property p_override;
        @(posedge clock) disable iff (!rstn)
        $rose(|act) |=> pin_override;
    endproperty
    a_override: assert property (p_override) else $error("no override");

    property p_read_count;
        @(posedge clock) disable iff (!rstn)
        (io_rd && io_addr == `T2_OFS_COUNT) |=> io_rdata == $past(cnt_q);
    endproperty
    a_read_count: assert property (p_read_count) else $error("bad read");

    property p_phase_turn;
        @(posedge clock) disable iff (!rstn)
        (mode == timer2_pkg::MODE_PHASE && tick && down_q
         && cnt_q == `T2_BOTTOM && !apply_vec[2]) |=> !down_q ##0 ovf_q;
    endproperty
    a_phase_turn: assert property (p_phase_turn) else $error("no turn");

    c_ovf:   cover property (@(posedge clock) disable iff (!rstn) ovf_q);
    c_fast:  cover property (@(posedge clock) disable iff (!rstn)
                             mode == timer2_pkg::MODE_FAST && match_q);
    c_xfer:  cover property (@(posedge clock) disable iff (!rstn)
                             $fell(pend_q[2]));

endmodule

// ### sim/async_timer2_control_tb_top.sv
/*
 * self-checking bench for the asynchronous 8-bit timer block.
 * assumes the design files and timer2_params.svh are compiled first.
 */
`timescale 1ns/1ps
`include "timer2_params.svh"

module async_timer2_control_tb_top;
    // ==========================================================
    // signals
    logic       clock;
    logic       rstn;
    logic [5:0] io_addr;
    logic       io_wr;
    logic       io_rd;
    logic [7:0] io_wdata;
    logic [7:0] io_rdata;
    logic       crystal_clock_in = 1'b0;
    logic       compare_output_pin;
    logic       pin_override;
    logic       overflow_flag;
    logic       compare_match;
    logic       xtal_run;
    logic [2:0] xtal_cnt = 3'h0;
    logic [7:0] d;
    logic [7:0] a;
    int         n;
    int         k;
    int         fails;
    int         n_compared;
    // division ratio per clock select code
    int         ratio [8] = '{0, 1, 8, 32, 64, 128, 256, 1024};

    // ==========================================================
    // design under test
    async_timer2_control uut (
        .clock              (clock),
        .rstn               (rstn),
        .io_addr            (io_addr),
        .io_wr              (io_wr),
        .io_rd              (io_rd),
        .io_wdata           (io_wdata),
        .io_rdata           (io_rdata),
        .crystal_clock_in   (crystal_clock_in),
        .compare_output_pin (compare_output_pin),
        .pin_override       (pin_override),
        .overflow_flag      (overflow_flag),
        .compare_match      (compare_match)
    );

    // 250 mhz clock
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    // crystal: half period of 5 clocks, freezes while stopped
    always @(posedge clock) begin
        if (xtal_run) begin
            if (xtal_cnt == 3'h4) begin
                xtal_cnt         <= 3'h0;
                crystal_clock_in <= ~crystal_clock_in;
            end else begin
                xtal_cnt <= xtal_cnt + 3'h1;
            end
        end
    end

    // ==========================================================
    // tasks
    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp,
                         input string what);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask

    // one write, strobe taken at the next edge
    task automatic wr(input logic [5:0] ad, input logic [7:0] dt);
        io_addr  <= ad;
        io_wdata <= dt;
        io_wr    <= 1'b1;
        @(posedge clock);
        io_wr    <= 1'b0;
        @(posedge clock);
    endtask

    // one read, data held from the edge after the strobe
    task automatic rd(input logic [5:0] ad, output logic [7:0] dt);
        io_addr <= ad;
        io_rd   <= 1'b1;
        @(posedge clock);
        io_rd   <= 1'b0;
        @(posedge clock);
        dt = io_rdata;
    endtask

    task automatic rdc(input logic [5:0] ad, input logic [7:0] exp);
        logic [7:0] v;
        rd(ad, v);
        check(v, exp, "register read");
    endtask

    // cycles until the next event pulse, bounded
    task automatic wait_pulse(input bit ovf, input int lim, output int c);
        c = 0;
        while (1) begin
            @(posedge clock);
            c++;
            if ((ovf ? overflow_flag : compare_match) === 1'b1) begin
                return;
            end
            if (c >= lim) begin
                fails++;
                $display("BAD %0t event wait ran out", $time);
                report_and_stop();
            end
        end
    endtask

    // pending bits cleared within a bounded number of polls
    task automatic wait_idle;
        logic [7:0] v;
        for (int i = 0; i < 40; i++) begin
            rd(`T2_OFS_STATUS, v);
            if (v[2:0] === 3'h0) begin
                return;
            end
        end
        fails++;
        $display("BAD %0t pending bits stuck", $time);
        report_and_stop();
    endtask

    // high cycles of the pin over one overflow period
    task automatic duty(input logic [7:0] ctl, input logic [7:0] cmp,
                        input int win, input int e, input int tol);
        int c;
        int h;
        h = 0;
        wr(`T2_OFS_COMPARE, cmp);
        wr(`T2_OFS_CONTROL, ctl);
        wait_pulse(1'b1, 1100, c);
        wait_pulse(1'b1, 1100, c);
        check(c, win, "overflow period");
        for (int i = 0; i < win; i++) begin
            @(posedge clock);
            if (compare_output_pin === 1'b1) h++;
        end
        check((h >= e) && (h <= e + tol), 1'b1, "pwm duty");
    endtask

    // ==========================================================
    // main sequence
    initial begin
        rstn = 1'b0; io_addr = 6'h00; io_wr = 1'b0; io_rd = 1'b0;
        io_wdata = 8'h00; xtal_run = 1'b0;
        fails = 0; n_compared = 0;
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
        // reset values and access kinds
        rdc(`T2_OFS_STATUS, 8'h00);
        rdc(`T2_OFS_COMPARE, 8'h00);
        rdc(`T2_OFS_COUNT, 8'h00);
        rdc(`T2_OFS_CONTROL, 8'h00);
        wr(`T2_OFS_COMPARE, 8'ha5);
        rdc(`T2_OFS_COMPARE, 8'ha5);
        wr(`T2_OFS_CONTROL, 8'hff);
        rdc(`T2_OFS_CONTROL, 8'h7f);
        wr(`T2_OFS_CONTROL, 8'h00);
        wr(`T2_OFS_STATUS, 8'hff);
        rdc(`T2_OFS_STATUS, 8'h08);
        wr(`T2_OFS_STATUS, 8'h00);
        wr(6'h30, 8'hff);
        rdc(6'h30, 8'h00);
        wr(`T2_OFS_COUNT, 8'h10);
        repeat (20) @(posedge clock);
        rdc(`T2_OFS_COUNT, 8'h10);
        $display("test registers done");
        // prescale ratios in normal mode
        for (int i = 1; i < 4; i++) begin
            wr(`T2_OFS_CONTROL, i[7:0]);
            wait_pulse(1'b1, 20000, n);
            wait_pulse(1'b1, 20000, n);
            check(n, (i == 1) ? 256 : (i == 2) ? 2048 : 8192, "pre");
        end
        // clear-on-match at zero: one match per prescaled tick
        wr(`T2_OFS_COMPARE, 8'h00);
        for (int i = 2; i < 8; i++) begin
            wr(`T2_OFS_CONTROL, 8'h08 | i[7:0]);
            wait_pulse(1'b0, 3000, n);
            wait_pulse(1'b0, 3000, n);
            check(n, ratio[i], "ctc prescale");
        end
        $display("test prescaler done");
        // clear-on-match period and non-pwm pin actions
        wr(`T2_OFS_COMPARE, 8'h09);
        wr(`T2_OFS_CONTROL, 8'h19);
        wait_pulse(1'b0, 300, n);
        a = {7'h00, compare_output_pin};
        wait_pulse(1'b0, 300, n);
        check(n, 10, "ctc period");
        check(compare_output_pin, !a[0], "toggle");
        check(pin_override, 1'b1, "override on");
        for (int i = 2; i < 4; i++) begin
            wr(`T2_OFS_CONTROL, 8'h09 | (i[7:0] << 4));
            wait_pulse(1'b0, 300, n);
            wait_pulse(1'b0, 300, n);
            check(compare_output_pin, i[0], "clear or set");
        end
        wr(`T2_OFS_CONTROL, 8'h09);
        // override follows the action field one edge later
        @(posedge clock);
        check(pin_override, 1'b0, "override off");
        $display("test clear on match done");
        // counter write masks the next match
        wr(`T2_OFS_CONTROL, 8'h01);
        wr(`T2_OFS_COMPARE, 8'h20);
        wr(`T2_OFS_COUNT, 8'h20);
        wait_pulse(1'b0, 300, n);
        check(n > 200, 1'b1, "masked match");
        wr(`T2_OFS_COUNT, 8'h1e);
        wait_pulse(1'b0, 300, n);
        check(n < 8, 1'b1, "prompt match");
        $display("test match mask done");
        // pwm waveforms
        duty(8'h69, 8'h40, 256, 64, 1);
        duty(8'h79, 8'h40, 256, 191, 1);
        duty(8'h69, 8'hff, 256, 256, 0);
        duty(8'h79, 8'hff, 256, 0, 0);
        duty(8'h61, 8'h40, 510, 128, 0);
        duty(8'h71, 8'h40, 510, 382, 0);
        duty(8'h61, 8'hff, 510, 0, 0);
        duty(8'h71, 8'hff, 510, 510, 0);
        $display("test pwm done");
        // asynchronous staging and pending bits
        wr(`T2_OFS_STATUS, 8'h08);
        wr(`T2_OFS_COUNT, 8'h55);
        wr(`T2_OFS_COMPARE, 8'h33);
        wr(`T2_OFS_CONTROL, 8'h00);
        rdc(`T2_OFS_STATUS, 8'h0f);
        repeat (40) @(posedge clock);
        rdc(`T2_OFS_STATUS, 8'h0f);
        rdc(`T2_OFS_COMPARE, 8'h33);
        xtal_run <= 1'b1;
        wait_idle();
        rdc(`T2_OFS_COUNT, 8'h55);
        wr(`T2_OFS_CONTROL, 8'h01);
        wait_idle();
        xtal_run <= 1'b0;
        rd(`T2_OFS_COUNT, a);
        repeat (40) @(posedge clock);
        rdc(`T2_OFS_COUNT, a);
        xtal_run <= 1'b1;
        repeat (60) @(posedge clock);
        rd(`T2_OFS_COUNT, d);
        check(d != a, 1'b1, "crystal count");
        wr(`T2_OFS_STATUS, 8'h00);
        $display("test async done");
        report_and_stop();
    end
endmodule
